// ---- pbc_params.svh ----
`ifndef PBC_PARAMS_SVH
`define PBC_PARAMS_SVH

// timebase rate in MHz (100 ns period)
`define PBC_CLK_MHZ       10

// periods in microseconds; cycle counts are derived in the top module
`define PBC_DEBOUNCE_US   30000
`define PBC_INT_MIN_US    15000
`define PBC_RECOVERY_US   360000
`define PBC_BLANK_US      15000000

// number of synchroniser stages
`define PBC_SYNC_STAGES   2

`endif

// ---- pbc_pkg.sv ----
package pbc_pkg;

	// sequencer states, gray coded along the power-up path
	typedef enum logic [2:0] {
		PBC_ST_STANDBY  = 3'h0,
		PBC_ST_DEBOUNCE = 3'h1,
		PBC_ST_STARTUP  = 3'h3,
		PBC_ST_NORMAL   = 3'h2,
		PBC_ST_LPRESET  = 3'h6
	} pbc_state_t;

	// synchronised inputs, all active high
	typedef struct packed {
		logic pb_pressed;
		logic sr_pressed;
		logic hold;
		logic above_upper;
		logic below_lower;
		logic cap_fitted;
		logic delay_done;
	} pbc_in_t;

endpackage : pbc_pkg

// ---- pbc_sync.sv ----
`timescale 1ns/1ps
`include "pbc_params.svh"

module pbc_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             i_mclk,
	input  wire logic             i_rst_n,
	// data
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_reg [`PBC_SYNC_STAGES];

	// first stage feeds only the next stage
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < `PBC_SYNC_STAGES; i++) begin
				meta_reg[i] <= '0;
			end
		end else begin
			meta_reg[0] <= i_async;
			for (int i = 1; i < `PBC_SYNC_STAGES; i++) begin
				meta_reg[i] <= meta_reg[i-1];
			end
		end
	end

	assign o_sync = meta_reg[`PBC_SYNC_STAGES-1];

endmodule : pbc_sync

// ---- pbc_timer.sv ----
`timescale 1ns/1ps

module pbc_timer #(
	parameter int LIMIT = 1
) (
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	// control
	input  wire logic i_run,
	output logic      o_done
);

	localparam int             W    = (LIMIT > 1) ? $clog2(LIMIT) : 1;
	localparam logic [W-1:0]   LAST = W'(LIMIT - 1);

	logic [W-1:0] cnt_reg;

	// clears whenever the run condition drops, saturates at the end
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg <= '0;
		end else if (!i_run) begin
			cnt_reg <= '0;
		end else if (cnt_reg != LAST) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	assign o_done = i_run && (cnt_reg == LAST);

endmodule : pbc_timer

// ---- pbc_top.sv ----
`timescale 1ns/1ps
`include "pbc_params.svh"
// What this block does
// - power-up starts only after button held full debounce with supply above upper threshold.
// - supply dropping during debounce clears the count; counting restarts when supply returns.
// - debounce done asserts enable and pulls reset low for the recovery period.
// - button-held variant: hold low at button release during startup drops enable.
// - button-held variant: blanking expiry before release samples hold; low drops enable.
// - button-held variant: no status, interrupt or undervoltage monitoring before power-up completes.
// - fixed variant: hold ignored during blanking; low at blanking end drops enable.
// - fixed variant: status, interrupt, undervoltage unmonitored for the whole blanking period.
// - fixed variant startup: status answers only the first press until blanking ends.
// - debounced press holds status low minimum width, then high on release.
// - status ignores button presses while undervoltage is present.
// - normal debounced press drives interrupt low while held; high during power-up.
// - normal operation: supply below lower threshold drives interrupt low.
// - while enable stays on, every interrupt assertion lasts at least the minimum interrupt width.
// - undervoltage lasting debounce plus minimum width plus long-push delay drops enable.
// - normal operation: power-hold low drops enable.
// - reset option: both buttons held past long push asserts reset for recovery.
// - power-off option: same long push drops enable instead of reset.
// - reset option: after long-push reset, hold not high by blanking end drops enable.
// - enable off means standby: only watch for a press, reference output disabled.
// - build option selects enable polarity, active high or active low.
// - no delay capacitor fitted means zero long-push delay.
module pbc_top #(
	parameter bit HELD_VARIANT       = 1'b1,
	parameter bit LONG_PUSH_OFF      = 1'b0,
	parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
	parameter int DEBOUNCE_CYC       = `PBC_DEBOUNCE_US * `PBC_CLK_MHZ,
	parameter int INT_MIN_CYC        = `PBC_INT_MIN_US * `PBC_CLK_MHZ,
	parameter int RECOVERY_CYC       = `PBC_RECOVERY_US * `PBC_CLK_MHZ,
	parameter int BLANK_CYC          = `PBC_BLANK_US * `PBC_CLK_MHZ
) (
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	// buttons and host
	input  wire logic i_power_button_n,
	input  wire logic i_second_reset_button_n,
	input  wire logic i_power_hold_in,
	// supply comparators
	input  wire logic i_supply_above_upper,
	input  wire logic i_supply_below_lower,
	// long-push delay capacitor sense
	input  wire logic i_long_push_delay_cap,
	input  wire logic i_long_push_delay_done,
	// power and reset outputs
	output logic      o_enable,
	output logic      o_reset_n,
	output logic      o_vref_en,
	// host status outputs
	output logic      o_int_n,
	output logic      o_button_status_n,
	output logic      o_supply_low_n,
	// delay capacitor charge request
	output logic      o_delay_charge
);

	localparam bit EN_ON  = ENABLE_ACTIVE_HIGH;
	localparam bit EN_OFF = !ENABLE_ACTIVE_HIGH;
	localparam int LP_CYC = DEBOUNCE_CYC + INT_MIN_CYC;

	pbc_pkg::pbc_in_t    raw;
	pbc_pkg::pbc_in_t    s;
	pbc_pkg::pbc_state_t state_reg;
	pbc_pkg::pbc_state_t state_next;

	logic pb_prev_reg;
	logic pb_fall;
	logic deb_done;
	logic blank_done;
	logic rec_done;
	logic btn_done;
	logic stat_done;
	logic int_done;
	logic lp_done;
	logic uv_done;
	logic lp_hit;
	logic uv_hit;
	logic mon;
	logic en_next;
	logic rst_trig;
	logic first_press;
	logic int_cause;

	function automatic logic is_on(input pbc_pkg::pbc_state_t st);
		is_on = (st == pbc_pkg::PBC_ST_STARTUP) || (st == pbc_pkg::PBC_ST_NORMAL) ||
			(st == pbc_pkg::PBC_ST_LPRESET);
	endfunction : is_on

	assign raw.pb_pressed  = !i_power_button_n;
	assign raw.sr_pressed  = !i_second_reset_button_n;
	assign raw.hold        = i_power_hold_in;
	assign raw.above_upper = i_supply_above_upper;
	assign raw.below_lower = i_supply_below_lower;
	assign raw.cap_fitted  = i_long_push_delay_cap;
	assign raw.delay_done  = i_long_push_delay_done;

	pbc_sync #(
		.WIDTH ($bits(pbc_pkg::pbc_in_t))
	) u_sync (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_async (raw),
		.o_sync  (s)
	);

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pb_prev_reg <= 1'b0;
		end else begin
			pb_prev_reg <= s.pb_pressed;
		end
	end

	assign pb_fall = s.pb_pressed && !pb_prev_reg;
	assign mon     = (state_reg == pbc_pkg::PBC_ST_NORMAL);

	// debounce runs only while both button and supply are good
	pbc_timer #(.LIMIT(DEBOUNCE_CYC)) u_deb (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_run   ((state_reg == pbc_pkg::PBC_ST_DEBOUNCE) && s.pb_pressed && s.above_upper),
		.o_done  (deb_done)
	);

	pbc_timer #(.LIMIT(BLANK_CYC)) u_blank (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_run   ((state_reg == pbc_pkg::PBC_ST_STARTUP) || (state_reg == pbc_pkg::PBC_ST_LPRESET)),
		.o_done  (blank_done)
	);

	pbc_timer #(.LIMIT(RECOVERY_CYC)) u_rec (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_run   (!o_reset_n),
		.o_done  (rec_done)
	);

	pbc_timer #(.LIMIT(DEBOUNCE_CYC)) u_btn (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_run   (mon && s.pb_pressed && !s.below_lower),
		.o_done  (btn_done)
	);

	pbc_timer #(.LIMIT(INT_MIN_CYC)) u_stat (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_run   (!o_button_status_n),
		.o_done  (stat_done)
	);

	pbc_timer #(.LIMIT(INT_MIN_CYC)) u_int (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_run   (!o_int_n),
		.o_done  (int_done)
	);

	pbc_timer #(.LIMIT(LP_CYC)) u_lp (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_run   (mon && s.pb_pressed && s.sr_pressed),
		.o_done  (lp_done)
	);

	pbc_timer #(.LIMIT(LP_CYC)) u_uv (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_run   (mon && s.below_lower),
		.o_done  (uv_done)
	);

	// capacitor delay follows the fixed part; absent cap means no extra delay
	assign lp_hit = lp_done && (s.delay_done || !s.cap_fitted);
	assign uv_hit = uv_done && (s.delay_done || !s.cap_fitted);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			pbc_pkg::PBC_ST_STANDBY: begin
				if (pb_fall) state_next = pbc_pkg::PBC_ST_DEBOUNCE;
			end
			pbc_pkg::PBC_ST_DEBOUNCE: begin
				if (!s.pb_pressed) state_next = pbc_pkg::PBC_ST_STANDBY;
				else if (deb_done) state_next = pbc_pkg::PBC_ST_STARTUP;
			end
			pbc_pkg::PBC_ST_STARTUP: begin
				if (HELD_VARIANT && !s.pb_pressed) begin
					state_next = s.hold ? pbc_pkg::PBC_ST_NORMAL : pbc_pkg::PBC_ST_STANDBY;
				end else if (blank_done) begin
					state_next = s.hold ? pbc_pkg::PBC_ST_NORMAL : pbc_pkg::PBC_ST_STANDBY;
				end
			end
			pbc_pkg::PBC_ST_NORMAL: begin
				if (!s.hold || uv_hit || (lp_hit && LONG_PUSH_OFF)) begin
					state_next = pbc_pkg::PBC_ST_STANDBY;
				end else if (lp_hit) begin
					state_next = pbc_pkg::PBC_ST_LPRESET;
				end
			end
			pbc_pkg::PBC_ST_LPRESET: begin
				// hold is ignored until blanking ends, as in fixed-variant startup
				if (blank_done) begin
					state_next = s.hold ? pbc_pkg::PBC_ST_NORMAL : pbc_pkg::PBC_ST_STANDBY;
				end
			end
			default: state_next = pbc_pkg::PBC_ST_STANDBY;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= pbc_pkg::PBC_ST_STANDBY;
		end else begin
			state_reg <= state_next;
		end
	end

	assign en_next     = is_on(state_next);
	assign rst_trig    = (state_reg == pbc_pkg::PBC_ST_DEBOUNCE && state_next == pbc_pkg::PBC_ST_STARTUP) ||
		(state_reg == pbc_pkg::PBC_ST_NORMAL && state_next == pbc_pkg::PBC_ST_LPRESET);
	assign first_press = !HELD_VARIANT && (state_reg == pbc_pkg::PBC_ST_DEBOUNCE) &&
		(state_next == pbc_pkg::PBC_ST_STARTUP);
	assign int_cause   = mon && (btn_done || s.below_lower);

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_enable  <= EN_OFF;
			o_vref_en <= 1'b0;
		end else begin
			o_enable  <= en_next ? EN_ON : EN_OFF;
			o_vref_en <= en_next;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reset_n <= 1'b1;
		end else if (!en_next) begin
			o_reset_n <= 1'b1;
		end else if (rst_trig) begin
			o_reset_n <= 1'b0;
		end else if (rec_done) begin
			o_reset_n <= 1'b1;
		end
	end

	// press set wins over the release clear
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_button_status_n <= 1'b1;
		end else if (!en_next) begin
			o_button_status_n <= 1'b1;
		end else if (btn_done || first_press) begin
			o_button_status_n <= 1'b0;
		end else if (stat_done && !s.pb_pressed) begin
			o_button_status_n <= 1'b1;
		end
	end

	// while enable stays on, interrupt cannot be released before its minimum width has run
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_int_n <= 1'b1;
		end else if (!en_next) begin
			o_int_n <= 1'b1;
		end else if (int_cause) begin
			o_int_n <= 1'b0;
		end else if (int_done) begin
			o_int_n <= 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_supply_low_n <= 1'b1;
			o_delay_charge <= 1'b0;
		end else begin
			if (!en_next && state_next != pbc_pkg::PBC_ST_DEBOUNCE) begin
				o_supply_low_n <= 1'b1;
			end else if (state_next == pbc_pkg::PBC_ST_NORMAL) begin
				o_supply_low_n <= !s.below_lower;
			end else begin
				o_supply_low_n <= s.above_upper;
			end
			o_delay_charge <= s.cap_fitted && (lp_done || uv_done);
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	sequence debounce_exit_s;
		state_reg == pbc_pkg::PBC_ST_DEBOUNCE && deb_done;
	endsequence

	sequence startup_refused_s;
		state_reg == pbc_pkg::PBC_ST_STARTUP && !s.hold &&
			((HELD_VARIANT && !s.pb_pressed) || blank_done);
	endsequence

	power_up_cond_a: assert property ($rose(state_reg == pbc_pkg::PBC_ST_STARTUP) |->
		$past(s.pb_pressed) && $past(s.above_upper))
		else $error("startup entered without button and supply");
	debounce_clear_a: assert property (state_reg == pbc_pkg::PBC_ST_DEBOUNCE && !s.above_upper |=> !deb_done)
		else $error("debounce not cleared on low supply");
	enable_reset_a: assert property (debounce_exit_s |=> o_enable == EN_ON && !o_reset_n && o_int_n)
		else $error("enable and reset not applied after debounce");
	held_release_off_a: assert property ((HELD_VARIANT and startup_refused_s) |=> o_enable == EN_OFF ##1
		state_reg == pbc_pkg::PBC_ST_STANDBY)
		else $error("held variant did not drop enable");
	blank_end_off_a: assert property ((!HELD_VARIANT and startup_refused_s) |=> o_enable == EN_OFF && !o_vref_en)
		else $error("fixed variant did not drop enable");
	startup_quiet_a: assert property (state_reg == pbc_pkg::PBC_ST_STARTUP && $past(state_reg) ==
		pbc_pkg::PBC_ST_STARTUP |-> o_int_n && !btn_done)
		else $error("monitoring active during startup");
	status_uv_a: assert property (mon && s.below_lower |=> !btn_done)
		else $error("press counted during undervoltage");
	int_width_a: assert property ($rose(o_int_n) && o_enable == EN_ON |-> $past(int_done))
		else $error("interrupt shorter than minimum width");
	hold_low_off_a: assert property (mon && !s.hold |=> o_enable == EN_OFF)
		else $error("hold low did not drop enable");
	long_push_a: assert property (mon && lp_hit && s.hold && !uv_hit |=>
		(LONG_PUSH_OFF ? o_enable == EN_OFF : !o_reset_n))
		else $error("long push not acted on");
	standby_vref_a: assert property (state_reg == pbc_pkg::PBC_ST_STANDBY |-> o_enable == EN_OFF && !o_vref_en)
		else $error("reference on in standby");

endmodule : pbc_top

// ---- pbc_host.sv ----
`timescale 1ns/1ps

module pbc_host #(
	parameter int CONFIRM_DLY = 3
) (
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	// from the controller
	input  wire logic i_powered,
	input  wire logic i_cpu_reset_n,
	// bench commands
	input  wire logic i_confirm,
	input  wire logic i_shutdown,
	// to the controller
	output logic      o_power_hold
);
	int boot_cnt;

	// unpowered or in reset the pin floats, so the pull-down wins
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			boot_cnt     <= 0;
			o_power_hold <= 1'b0;
		end else if (!i_powered || !i_cpu_reset_n) begin
			boot_cnt     <= 0;
			o_power_hold <= 1'b0;
		end else begin
			if (boot_cnt < CONFIRM_DLY) begin
				boot_cnt <= boot_cnt + 1;
			end
			o_power_hold <= i_confirm && !i_shutdown && (boot_cnt >= CONFIRM_DLY - 1);
		end
	end
endmodule : pbc_host

// ---- pbc_top_tb.sv ----
`timescale 1ns/1ps

module pbc_top_tb;
	localparam int DEB = 8;
	localparam int IMIN = 4;
	localparam int REC = 6;
	localparam int BLANK = 40;

	logic mclk;
	logic rst_n;
	logic pb_n;
	logic sr_n;
	logic hold;
	logic above;
	logic below;
	logic cap;
	logic done;
	logic confirm;
	logic shutdown;
	logic o_enable;
	logic o_reset_n;
	logic o_vref_en;
	logic o_int_n;
	logic o_status_n;
	logic o_supply_low_n;
	logic chg;
	logic hold2;
	logic en2;
	logic rst2_n;
	logic int2_n;
	logic stat2_n;
	int   err_total;
	int   comparisons;
	int   n;

	pbc_top #(.HELD_VARIANT(1'b1), .LONG_PUSH_OFF(1'b0), .ENABLE_ACTIVE_HIGH(1'b1),
		.DEBOUNCE_CYC(DEB), .INT_MIN_CYC(IMIN), .RECOVERY_CYC(REC), .BLANK_CYC(BLANK)) DUT (
		.i_mclk(mclk), .i_rst_n(rst_n), .i_power_button_n(pb_n), .i_second_reset_button_n(sr_n),
		.i_power_hold_in(hold), .i_supply_above_upper(above), .i_supply_below_lower(below),
		.i_long_push_delay_cap(cap), .i_long_push_delay_done(done), .o_enable(o_enable),
		.o_reset_n(o_reset_n), .o_vref_en(o_vref_en), .o_int_n(o_int_n),
		.o_button_status_n(o_status_n), .o_supply_low_n(o_supply_low_n), .o_delay_charge(chg));

	pbc_host #(.CONFIRM_DLY(3)) host (
		.i_mclk(mclk), .i_rst_n(rst_n), .i_powered(o_enable), .i_cpu_reset_n(o_reset_n),
		.i_confirm(confirm), .i_shutdown(shutdown), .o_power_hold(hold));

	// second build: fixed blanking, power-off on long push, active-low enable
	pbc_top #(.HELD_VARIANT(1'b0), .LONG_PUSH_OFF(1'b1), .ENABLE_ACTIVE_HIGH(1'b0),
		.DEBOUNCE_CYC(DEB), .INT_MIN_CYC(IMIN), .RECOVERY_CYC(REC), .BLANK_CYC(BLANK)) DUT2 (
		.i_mclk(mclk), .i_rst_n(rst_n), .i_power_button_n(pb_n), .i_second_reset_button_n(sr_n),
		.i_power_hold_in(hold2), .i_supply_above_upper(above), .i_supply_below_lower(below),
		.i_long_push_delay_cap(cap), .i_long_push_delay_done(done), .o_enable(en2),
		.o_reset_n(rst2_n), .o_vref_en(), .o_int_n(int2_n),
		.o_button_status_n(stat2_n), .o_supply_low_n(), .o_delay_charge());

	pbc_host #(.CONFIRM_DLY(3)) host2 (
		.i_mclk(mclk), .i_rst_n(rst_n), .i_powered(!en2), .i_cpu_reset_n(rst2_n),
		.i_confirm(confirm), .i_shutdown(shutdown), .o_power_hold(hold2));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic check(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t mismatch got %b exp %b", $time, got, exp);
		end
	endtask : check

	function automatic logic pick(input int k);
		case (k)
			0: pick = o_enable;
			1: pick = o_reset_n;
			2: pick = o_int_n;
			default: pick = o_status_n;
		endcase
	endfunction : pick

	// inputs move and outputs are sampled at the falling edge only
	task automatic wait_for(input int k, input logic v, input int lim);
		for (int i = 0; i < lim && pick(k) !== v; i++) @(negedge mclk);
		check(pick(k), v);
	endtask : wait_for

	task automatic count_low(input int k, output int c);
		c = 0;
		while (pick(k) === 1'b0 && c < 200) begin
			@(negedge mclk);
			c++;
		end
	endtask : count_low

	task automatic power_up();
		pb_n = 1'b0;
		wait_for(0, 1'b1, 30);
		check(o_int_n, 1'b1);
		wait_for(1, 1'b1, 20);
		for (int i = 0; i < 20 && hold !== 1'b1; i++) @(negedge mclk);
		pb_n = 1'b1;
		repeat (5) @(negedge mclk);
		check(o_enable, 1'b1);
	endtask : power_up

	task automatic t_powerup_dip();
		confirm = 1'b0;
		pb_n = 1'b0;
		repeat (5) @(negedge mclk);
		above = 1'b0;
		repeat (2) @(negedge mclk);
		above = 1'b1;
		repeat (5) @(negedge mclk);
		check(o_enable, 1'b0);
		wait_for(0, 1'b1, 30);
		check(o_vref_en, 1'b1);
		check(en2, 1'b0);
		check(stat2_n, 1'b0);
		count_low(1, n);
		check(n == REC, 1'b1);
		pb_n = 1'b1;
		wait_for(0, 1'b0, 4);
		check(en2, 1'b0);
		check(o_vref_en, 1'b0);
	endtask : t_powerup_dip

	task automatic t_press_int();
		confirm = 1'b1;
		repeat (3) @(negedge mclk);
		power_up();
		check(en2, 1'b0);
		check(stat2_n, 1'b1);
		check(int2_n, 1'b1);
		pb_n = 1'b0;
		wait_for(2, 1'b0, DEB + 5);
		pb_n = 1'b1;
		count_low(2, n);
		check(n + 1 >= IMIN, 1'b1);
		repeat (4) @(negedge mclk);
		pb_n = 1'b0;
		wait_for(3, 1'b0, DEB + 5);
		repeat (IMIN + 4) @(negedge mclk);
		check(o_int_n, 1'b0);
		pb_n = 1'b1;
		wait_for(3, 1'b1, 4);
		wait_for(2, 1'b1, 6);
	endtask : t_press_int

	task automatic t_undervolt();
		below = 1'b1;
		wait_for(2, 1'b0, 4);
		check(o_supply_low_n, 1'b0);
		repeat (5) @(negedge mclk);
		check(o_enable, 1'b1);
		wait_for(0, 1'b0, 15);
		check(en2, 1'b1);
		below = 1'b0;
		repeat (4) @(negedge mclk);
	endtask : t_undervolt

	task automatic t_long_push();
		power_up();
		cap = 1'b1;
		pb_n = 1'b0;
		sr_n = 1'b0;
		repeat (DEB + IMIN + 6) @(negedge mclk);
		check(o_reset_n, 1'b1);
		check(chg, 1'b1);
		check(int2_n, 1'b1);
		check(stat2_n, 1'b1);
		done = 1'b1;
		wait_for(1, 1'b0, 5);
		count_low(1, n);
		check(n == REC, 1'b1);
		pb_n = 1'b1;
		sr_n = 1'b1;
		done = 1'b0;
		repeat (BLANK + 4) @(negedge mclk);
		check(o_enable, 1'b1);
	endtask : t_long_push

	task automatic t_hold_drop();
		shutdown = 1'b1;
		wait_for(0, 1'b0, 5);
		check(en2, 1'b1);
		check(o_vref_en, 1'b0);
		shutdown = 1'b0;
	endtask : t_hold_drop

	// blanking expiry with no confirm, then a bare long push with no delay cap
	task automatic t_long_off();
		confirm = 1'b0;
		pb_n = 1'b0;
		wait_for(0, 1'b1, 30);
		check(en2, 1'b0);
		wait_for(0, 1'b0, BLANK + 5);
		check(en2, 1'b1);
		pb_n = 1'b1;
		confirm = 1'b1;
		repeat (3) @(negedge mclk);
		power_up();
		cap = 1'b0;
		repeat (BLANK) @(negedge mclk);
		check(en2, 1'b0);
		pb_n = 1'b0;
		sr_n = 1'b0;
		repeat (DEB + IMIN) @(negedge mclk);
		check(o_reset_n, 1'b1);
		wait_for(1, 1'b0, 5);
		check(en2, 1'b1);
		pb_n = 1'b1;
		sr_n = 1'b1;
	endtask : t_long_off

	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (1000) @(posedge mclk);
		err_total++;
		report_and_stop();
	end

	initial begin
		err_total = 0;
		comparisons = 0;
		rst_n = 1'b0;
		pb_n = 1'b1;
		sr_n = 1'b1;
		above = 1'b1;
		below = 1'b0;
		cap = 1'b0;
		done = 1'b0;
		confirm = 1'b0;
		shutdown = 1'b0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		repeat (2) @(negedge mclk);
		t_powerup_dip();
		t_press_int();
		t_undervolt();
		t_long_push();
		t_hold_drop();
		t_long_off();
		report_and_stop();
	end
endmodule : pbc_top_tb
